// [core/mode_and_access_protection.sv]
// mode, register-bank and page permission checker with its register file
// assumes the pipeline presents one access per req_valid pulse on aclk
// and takes the verdict one cycle later; software uses axi4-lite
//
// Summary of operation
// - supervisor flag one means supervisor mode
// - special registers 160 to 255 always trap
// - supervisor ignores bank guard bits
// - user access to tlb registers traps
// - user load/store with physical or user flag traps
// - user return, invalidate, halt trap; halt maskable
// - user special registers 0-127, 160-255 trap
// - user assert/emulate vectors 0 to 63 trap
// - banks of sixteen by absolute number
// - guarded bank trap, locals after stack offset
// - guard register holds sixteen bits, upper reserved
// - user read/write/fetch needs matching permission
// - permission bits gate access after translation
// - supervisor loads/fetches free, stores need write
// - atomic load-then-store needs both permissions
// - denial raises data or instruction mmu trap
// - sixteen entries, two columns of eight
// - entries are sixty-four bits wide
// - each entry carries an eight-bit owner tag
// - page sizes 1 Kbyte to 16 Mbyte by four
// - separate page sizes or one four-way buffer
// - owner tag matches process tag unless global
// - only valid entries translate
`timescale 1ns/1ps
module mode_and_access_protection (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // request from the pipeline
  input wire logic req_valid,
  input wire logic [31:0] processor_status_word,
  input wire logic spr_access,
  input wire logic [7:0] spr_number,
  input wire logic tlb_reg_access,
  input wire logic [2:0] gpr_used,
  input wire logic [23:0] gpr_numbers,
  input wire logic [6:0] stack_offset,
  input wire logic priv_instr,
  input wire logic halt_instr,
  input wire logic halt_check_disable,
  input wire logic vector_instr,
  input wire logic [7:0] vector_number,
  input wire logic [1:0] mem_kind,
  input wire logic fetch,
  input wire logic mapped,
  input wire logic physical_address_flag,
  input wire logic user_access_flag,
  input wire logic [31:0] vaddr,
  // verdict to the pipeline
  output logic resp_valid,
  output logic trap_req,
  output logic [1:0] trap_cause,
  output logic access_go,
  output logic xlate_miss,
  output logic [31:0] phys_addr
);

  // ******************************************************************
  // storage
  // ******************************************************************
  logic [15:0] gpr_bank_guard;
  logic [31:0] config_reg;
  logic [1:0] last_cause;
  // index {buffer, column, set, word}: two buffers of 16 entries of 64 bits
  logic [31:0] tlb_mem [0:4*mode_prot_pkg::entry_count-1];
  logic aw_got;
  logic w_got;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // ******************************************************************
  // axi4-lite write side
  // ******************************************************************
  logic do_write;
  assign do_write = aw_got && w_got && !s_axi_bvalid;

  // address and data are taken in either order, answered when both held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mode_prot_pkg::resp_okay;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == mode_prot_pkg::guard_addr ||
                        aw_addr == mode_prot_pkg::config_addr ||
                        aw_addr == mode_prot_pkg::cause_addr ||
                        (aw_addr >= mode_prot_pkg::tlb_base_addr &&
                         aw_addr <= mode_prot_pkg::tlb_top_addr)) ?
                       mode_prot_pkg::resp_okay : mode_prot_pkg::resp_slverr;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // byte-lane merge of the held write data
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = nw[i*8 +: 8];
    end
    return res;
  endfunction : merge

  // guard and configuration registers; absent banks and reserved bits stay zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpr_bank_guard <= mode_prot_pkg::guard_reset[15:0];
      config_reg <= 32'h00000000;
    end else if (do_write) begin
      if (aw_addr == mode_prot_pkg::guard_addr) begin
        gpr_bank_guard <= 16'(merge({16'h0000, gpr_bank_guard}, w_data, w_strb)) &
                          mode_prot_pkg::guard_impl_mask;
      end else if (aw_addr == mode_prot_pkg::config_addr) begin
        config_reg <= merge(config_reg, w_data, w_strb) & mode_prot_pkg::config_mask;
      end
    end
  end

  // translation entries, one word per address
  always_ff @(posedge aclk) begin
    if (do_write && aw_addr >= mode_prot_pkg::tlb_base_addr &&
        aw_addr <= mode_prot_pkg::tlb_top_addr) begin
      tlb_mem[aw_addr[7:2]] <= merge(tlb_mem[aw_addr[7:2]], w_data, w_strb);
    end
  end

  // ******************************************************************
  // axi4-lite read side
  // ******************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= mode_prot_pkg::resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mode_prot_pkg::resp_okay;
      if (s_axi_araddr == mode_prot_pkg::guard_addr) begin
        s_axi_rdata <= {16'h0000, gpr_bank_guard};
      end else if (s_axi_araddr == mode_prot_pkg::config_addr) begin
        s_axi_rdata <= config_reg;
      end else if (s_axi_araddr == mode_prot_pkg::cause_addr) begin
        s_axi_rdata <= {30'h00000000, last_cause};
      end else if (s_axi_araddr >= mode_prot_pkg::tlb_base_addr &&
                   s_axi_araddr <= mode_prot_pkg::tlb_top_addr) begin
        s_axi_rdata <= tlb_mem[s_axi_araddr[7:2]];
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= mode_prot_pkg::resp_slverr;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ******************************************************************
  // mode and register checks
  // ******************************************************************
  logic supervisor;
  logic [7:0] process_tag;
  logic user_trap;
  logic spr_trap;
  logic gpr_trap;
  logic [7:0] abs_num;
  logic [7:0] gnum;

  assign supervisor = processor_status_word[mode_prot_pkg::sup_flag_pos];
  assign process_tag = config_reg[mode_prot_pkg::cfg_tag_lsb +: 8];
  assign spr_trap = spr_access && (spr_number >= mode_prot_pkg::spr_virtual_low ||
                    (!supervisor && spr_number <= mode_prot_pkg::spr_user_top));

  // bank check on absolute numbers, locals offset by the stack pointer first
  always_comb begin
    gpr_trap = 1'b0;
    abs_num = 8'h00;
    gnum = 8'h00;
    for (int i = 0; i < 3; i++) begin
      gnum = gpr_numbers[i*8 +: 8];
      abs_num = (gnum >= mode_prot_pkg::local_base) ?
                {1'b1, 7'(gnum[6:0] + stack_offset)} : gnum;
      if (gpr_used[i] && gpr_bank_guard[abs_num[7:4]]) gpr_trap = 1'b1;
    end
    if (supervisor) gpr_trap = 1'b0;
  end

  assign user_trap = !supervisor && (tlb_reg_access ||
                     (mem_kind != mode_prot_pkg::mem_none &&
                      (physical_address_flag || user_access_flag)) ||
                     priv_instr || (halt_instr && !halt_check_disable) ||
                     (vector_instr && vector_number <= mode_prot_pkg::vector_user_top));

  // ******************************************************************
  // translation lookup over both buffers and both columns
  // ******************************************************************
  logic hit;
  logic [31:0] hit_w0;
  logic [31:0] hit_w1;
  logic [2:0] ps;
  logic [4:0] off;
  logic [2:0] set_idx;
  logic [31:0] low_mask;
  logic [31:0] cw0;
  logic [31:0] cw1;

  always_comb begin
    hit = 1'b0;
    hit_w0 = 32'h00000000;
    hit_w1 = 32'h00000000;
    ps = 3'h0;
    off = 5'h00;
    set_idx = 3'h0;
    low_mask = 32'h00000000;
    cw0 = 32'h00000000;
    cw1 = 32'h00000000;
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < 2; c++) begin
        // joined buffers share one page size, else each has its own
        ps = (b == 1 && !config_reg[mode_prot_pkg::cfg_join_pos]) ?
             config_reg[mode_prot_pkg::cfg_ps1_lsb +: 3] :
             config_reg[mode_prot_pkg::cfg_ps0_lsb +: 3];
        off = 5'(mode_prot_pkg::min_page_bits + mode_prot_pkg::page_step_bits * ps);
        set_idx = 3'(vaddr >> off);
        low_mask = (32'h1 << (off + 5'(mode_prot_pkg::set_bits))) - 32'h1;
        cw0 = tlb_mem[{1'(b), 1'(c), set_idx, 1'b0}];
        cw1 = tlb_mem[{1'(b), 1'(c), set_idx, 1'b1}];
        if (!hit && cw0[mode_prot_pkg::valid_pos] &&
            ((cw0 ^ vaddr) & ~low_mask & mode_prot_pkg::vtag_field) == 32'h0 &&
            (cw1[mode_prot_pkg::global_pos] || cw0[7:0] == process_tag)) begin
          hit = 1'b1;
          hit_w0 = cw0;
          hit_w1 = cw1 & ~((32'h1 << off) - 32'h1) & mode_prot_pkg::rpn_field;
          hit_w1 = hit_w1 | (vaddr & ((32'h1 << off) - 32'h1));
        end
      end
    end
  end

  // ******************************************************************
  // page permissions
  // ******************************************************************
  logic xlate;
  logic load_ok;
  logic store_ok;
  logic page_deny;
  logic is_load;
  logic is_store;

  assign xlate = mapped && (fetch || mem_kind != mode_prot_pkg::mem_none);
  assign is_load = mem_kind == mode_prot_pkg::mem_load || mem_kind == mode_prot_pkg::mem_load_store;
  assign is_store = mem_kind == mode_prot_pkg::mem_store ||
                    mem_kind == mode_prot_pkg::mem_load_store;
  assign load_ok = supervisor || hit_w0[mode_prot_pkg::ur_pos];
  assign store_ok = supervisor ? hit_w0[mode_prot_pkg::sw_pos] :
                    hit_w0[mode_prot_pkg::uw_pos];
  // atomic load-then-store fails as a whole when either half is denied
  assign page_deny = xlate && hit &&
                     ((fetch && !supervisor && !hit_w0[mode_prot_pkg::ue_pos]) ||
                      (is_load && !load_ok) || (is_store && !store_ok));

  // ******************************************************************
  // verdict to the pipeline
  // ******************************************************************
  mode_prot_pkg::cause_e next_cause;

  always_comb begin
    if (spr_trap || gpr_trap || user_trap) next_cause = mode_prot_pkg::cause_prot;
    else if (page_deny && fetch) next_cause = mode_prot_pkg::cause_instr_mmu;
    else if (page_deny) next_cause = mode_prot_pkg::cause_data_mmu;
    else next_cause = mode_prot_pkg::cause_none;
  end

  // one registered answer per request, access released only without a trap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resp_valid <= 1'b0;
      trap_req <= 1'b0;
      trap_cause <= mode_prot_pkg::cause_none;
      access_go <= 1'b0;
      xlate_miss <= 1'b0;
      phys_addr <= 32'h00000000;
    end else begin
      resp_valid <= req_valid;
      trap_req <= req_valid && next_cause != mode_prot_pkg::cause_none;
      trap_cause <= req_valid ? next_cause : mode_prot_pkg::cause_none;
      access_go <= req_valid && next_cause == mode_prot_pkg::cause_none &&
                   !(xlate && !hit);
      xlate_miss <= req_valid && xlate && !hit && next_cause == mode_prot_pkg::cause_none;
      phys_addr <= (xlate && hit) ? hit_w1 : vaddr;
    end
  end

  // cause of the latest trap, kept for software
  always_ff @(posedge aclk) begin
    if (!aresetn) last_cause <= mode_prot_pkg::cause_none;
    else if (req_valid && next_cause != mode_prot_pkg::cause_none) last_cause <= next_cause;
  end

  // ******************************************************************
  // assertions
  // ******************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  high_spr_a: assert property (req_valid && spr_access && spr_number >= 8'ha0 |=>
    trap_req && trap_cause == 2'h1) else $error("high special register not trapped");
  user_spr_a: assert property (req_valid && spr_access && !processor_status_word[4] &&
    spr_number < 8'h80 |=> trap_req) else $error("user low special register not trapped");
  sup_gpr_a: assert property (req_valid && processor_status_word[4] && !spr_access &&
    !page_deny |=> !trap_req) else $error("supervisor access trapped");
  user_tlb_a: assert property (req_valid && !processor_status_word[4] &&
    tlb_reg_access |=> trap_req) else $error("user tlb access not trapped");
  halt_mask_a: assert property (req_valid && !processor_status_word[4] && halt_instr &&
    !halt_check_disable |=> trap_req) else $error("user halt not trapped");
  vector_low_a: assert property (req_valid && !processor_status_word[4] && vector_instr &&
    vector_number <= 8'h3f |=> trap_req) else $error("low vector not trapped");
  guard_bits_a: assert property (gpr_bank_guard[3:0] == 4'h0)
    else $error("absent bank bit set");
  one_trap_a: assert property (trap_req |-> !access_go && resp_valid)
    else $error("trap with access released");
  fetch_cause_a: assert property (trap_req && trap_cause == 2'h3 |->
    $past(fetch) && $past(mapped)) else $error("instruction trap without fetch");
  sup_store_a: assert property (req_valid && processor_status_word[4] && xlate && hit &&
    mem_kind == 2'h2 && !hit_w0[11] && !spr_trap && !fetch |=> trap_cause == 2'h2)
    else $error("supervisor store to protected page allowed");
  bresp_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");

endmodule : mode_and_access_protection

// [core/mode_prot_pkg.sv]
// constants for the mode and access protection checker
// assumes a 32-bit axi4-lite register bus and a single processor clock
package mode_prot_pkg;

  // ******************************************************************
  // register map
  // ******************************************************************
  localparam logic [11:0] guard_index = 12'h007; // register number of gpr_bank_guard
  localparam logic [11:0] guard_addr = 12'h01c; // byte address, four times the index
  localparam logic [11:0] config_addr = 12'h020;
  localparam logic [11:0] cause_addr = 12'h024;
  localparam logic [11:0] tlb_base_addr = 12'h100;
  localparam logic [11:0] tlb_top_addr = 12'h1fc;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // ******************************************************************
  // field layout
  // ******************************************************************
  localparam int sup_flag_pos = 4; // supervisor_flag inside processor_status_word
  localparam logic [15:0] guard_impl_mask = 16'hfff0; // banks 0 to 3 absent
  localparam logic [31:0] guard_reset = 32'h00000000;
  localparam int cfg_tag_lsb = 0; // process_tag 7:0
  localparam int cfg_ps0_lsb = 8; // page size of first_xlate_buffer 10:8
  localparam int cfg_ps1_lsb = 12; // page size of second_xlate_buffer 14:12
  localparam int cfg_join_pos = 16; // one four-way buffer with one page size
  localparam logic [31:0] config_mask = 32'h000177ff;
  localparam int valid_pos = 12; // entry_valid_flag in word 0
  localparam int sw_pos = 11;
  localparam int ur_pos = 10;
  localparam int uw_pos = 9;
  localparam int ue_pos = 8;
  localparam int global_pos = 2; // global_page_flag in word 1
  localparam logic [31:0] vtag_field = 32'hffffe000;
  localparam logic [31:0] rpn_field = 32'hfffffc00;

  // ******************************************************************
  // numbers of the checks
  // ******************************************************************
  localparam logic [7:0] spr_user_top = 8'h7f; // 127
  localparam logic [7:0] spr_virtual_low = 8'ha0; // 160
  localparam logic [7:0] vector_user_top = 8'h3f; // 63
  localparam logic [7:0] local_base = 8'h80; // local registers begin here
  localparam int min_page_bits = 10; // 1 Kbyte
  localparam int page_step_bits = 2; // factor of four
  localparam int set_bits = 3; // eight sets per buffer
  localparam int entry_count = 16; // per buffer, two columns of eight

  // ******************************************************************
  // types
  // ******************************************************************
  typedef enum logic [1:0] {cause_none, cause_prot, cause_data_mmu, cause_instr_mmu} cause_e;
  typedef enum logic [1:0] {mem_none, mem_load, mem_store, mem_load_store} mem_e;

endpackage : mode_prot_pkg

// [dv/pipe_model.sv]
// pipeline stand-in: issues one request and gathers its verdict
// assumes the checker answers exactly one edge after req_valid
`timescale 1ns/1ps
module pipe_model (
  // clock
  input wire logic aclk,
  // request
  output logic req_valid,
  output logic [31:0] processor_status_word,
  output logic spr_access,
  output logic [7:0] spr_number,
  output logic tlb_reg_access,
  output logic [2:0] gpr_used,
  output logic [23:0] gpr_numbers,
  output logic [6:0] stack_offset,
  output logic priv_instr,
  output logic halt_instr,
  output logic halt_check_disable,
  output logic vector_instr,
  output logic [7:0] vector_number,
  output logic [1:0] mem_kind,
  output logic fetch,
  output logic mapped,
  output logic physical_address_flag,
  output logic user_access_flag,
  output logic [31:0] vaddr,
  // verdict
  input wire logic resp_valid,
  input wire logic trap_req,
  input wire logic [1:0] trap_cause,
  input wire logic access_go,
  input wire logic xlate_miss
);
  // ****
  // request driving
  // ****
  // idle every field so stale values cannot leak into the next request
  task automatic clr;
    {req_valid, processor_status_word, spr_access, spr_number, tlb_reg_access, gpr_used,
     gpr_numbers, stack_offset, priv_instr, halt_instr, halt_check_disable, vector_instr,
     vector_number, mem_kind, fetch, mapped, physical_address_flag, user_access_flag,
     vaddr} <= '0;
  endtask : clr

  initial clr();

  // one pulse; kind k picks the instruction class, v its operands
  task automatic go(input logic sup, input logic [2:0] k, input logic [31:0] v,
                    input logic [31:0] a, output logic [4:0] r);
    @(posedge aclk);
    req_valid <= 1'b1;
    processor_status_word[mode_prot_pkg::sup_flag_pos] <= sup;
    spr_access <= (k == 3'd0);
    spr_number <= v[7:0];
    tlb_reg_access <= (k == 3'd1);
    gpr_used <= {2'b00, k == 3'd2};
    gpr_numbers <= {16'h0, v[7:0]};
    stack_offset <= v[14:8];
    priv_instr <= (k == 3'd3);
    halt_instr <= (k == 3'd4);
    halt_check_disable <= (k == 3'd4) & v[0];
    vector_instr <= (k == 3'd5);
    vector_number <= v[7:0];
    mem_kind <= (k == 3'd6) ? v[1:0] : 2'b00;
    physical_address_flag <= (k == 3'd6) & v[2];
    user_access_flag <= (k == 3'd6) & v[3];
    mapped <= (k == 3'd6) ? v[4] : (k == 3'd7);
    fetch <= (k == 3'd7);
    vaddr <= a;
    @(posedge aclk);
    clr();
    #1;
    r = {xlate_miss, access_go, trap_req, trap_cause};
    if (resp_valid !== 1'b1) r = 5'bxxxxx; // a missing answer never matches
  endtask : go
endmodule : pipe_model

// [dv/mode_and_access_protection_bench.sv]
// self-checking bench for the protection checker
// assumes pipe_model in dv and the design package compiled first
`timescale 1ns/1ps
module mode_and_access_protection_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, processor_status_word, vaddr, phys_addr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, trap_cause, mem_kind;
  logic req_valid, spr_access, tlb_reg_access, priv_instr, halt_instr, halt_check_disable;
  logic vector_instr, fetch, mapped, physical_address_flag, user_access_flag;
  logic [7:0] spr_number, vector_number;
  logic [2:0] gpr_used;
  logic [23:0] gpr_numbers;
  logic [6:0] stack_offset;
  logic resp_valid, trap_req, access_go, xlate_miss;
  integer seed = 6635;
  int n_mismatch = 0;
  int check_count = 0;
  logic [4:0] r;
  logic [31:0] d, g, va;
  logic [1:0] rs;
  // {sup, kind, operands}: boundaries of every trap class
  localparam logic [19:0] corner [21] = '{20'h800a0, 20'h800ff, 20'h8009f, 20'h0007f,
    20'h00080, 20'h10000, 20'h90000, 20'h20040, 20'ha0040, 20'h20002, 20'h201ff,
    20'h30000, 20'hb0000, 20'h40000, 20'h40001, 20'h5003f, 20'h50040, 20'h60005,
    20'h60009, 20'he0005, 20'h60001};

  mode_and_access_protection uut (.*);
  pipe_model pipe (.*);

  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ****
  // shared tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rr);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rr);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // expected trap of a request that needs no translation
  function automatic logic prot(input logic sup, input logic [2:0] k, input logic [15:0] v);
    logic [7:0] n;
    n = v[7:0];
    if (k == 3'd2 && n[7]) n[6:0] = n[6:0] + v[14:8]; // locals rebased on the stack
    case (k)
      3'd0: return n >= 8'ha0 || (!sup && n <= 8'h7f);
      3'd1, 3'd3: return !sup;
      3'd2: return !sup && g[n[7:4]];
      3'd4: return !sup && !v[0];
      3'd5: return !sup && n <= 8'h3f;
      default: return !sup && v[1:0] != 2'b00 && (v[2] || v[3]);
    endcase
  endfunction : prot

  task automatic tv(input logic sup, input logic [2:0] k, input logic [31:0] v,
                    input logic [4:0] e);
    pipe.go(sup, k, v, va, r);
    chk({27'h0, r}, {27'h0, e});
  endtask : tv

  task automatic try(input logic sup, input logic [2:0] k, input logic [15:0] v);
    logic p;
    p = prot(sup, k, v);
    tv(sup, k, {16'h0, v}, {1'b0, !p, p, 1'b0, p});
  endtask : try

  task automatic tally_and_finish;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard, far beyond the expected run
  initial begin
    #400000;
    n_mismatch++;
    tally_and_finish();
  end

  // ****
  // main sequence
  // ****
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, va} = '0;
    s_axi_wstrb = 4'hf;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(mode_prot_pkg::guard_addr, d, rs);
    chk(d, 32'h0);
    rd(12'h040, d, rs);
    chk({30'h0, rs}, {30'h0, mode_prot_pkg::resp_slverr});
    wr(12'h040, 32'h00000001, rs);
    chk({30'h0, rs}, {30'h0, mode_prot_pkg::resp_slverr});
    wr(mode_prot_pkg::guard_addr, 32'hffffffff, rs);
    rd(mode_prot_pkg::guard_addr, d, rs);
    chk(d, 32'h0000fff0);
    g = d;
    foreach (corner[i]) try(corner[i][19], corner[i][18:16], corner[i][15:0]);
    g = $random(seed);
    wr(mode_prot_pkg::guard_addr, g, rs);
    g = g & 32'h0000fff0;
    repeat (80) begin
      d = $random(seed);
      try(d[31], d[30:28] % 3'd7, {d[15:5], 1'b0, d[3:0]});
    end
    va = 32'h12344123;
    wr(mode_prot_pkg::config_addr, 32'h5, rs);
    wr(mode_prot_pkg::tlb_base_addr, 32'h12345405, rs);
    wr(mode_prot_pkg::tlb_base_addr + 12'h4, 32'h0abc0000, rs);
    tv(0, 6, 32'h11, 5'b01000);
    chk(phys_addr, 32'h0abc0123);
    tv(0, 6, 32'h12, 5'b00110);
    tv(0, 6, 32'h13, 5'b00110);
    tv(0, 7, 32'h0, 5'b00111);
    rd(mode_prot_pkg::cause_addr, d, rs);
    chk(d, 32'h00000003);
    tv(1, 6, 32'h12, 5'b00110);
    tv(1, 7, 32'h0, 5'b01000);
    wr(mode_prot_pkg::tlb_base_addr, 32'h12345f05, rs);
    tv(1, 6, 32'h12, 5'b01000);
    tv(0, 6, 32'h13, 5'b01000);
    wr(mode_prot_pkg::config_addr, 32'h6, rs);
    tv(0, 6, 32'h11, 5'b10000);
    wr(mode_prot_pkg::tlb_base_addr + 12'h4, 32'h0abc0004, rs);
    tv(0, 6, 32'h11, 5'b01000);
    wr(mode_prot_pkg::tlb_base_addr, 32'h12344f05, rs);
    tv(1, 6, 32'h11, 5'b10000);
    // joined buffers on 4 Kbyte pages: only a buffer1 entry in set 4 can hit
    wr(mode_prot_pkg::config_addr, 32'h00012106, rs);
    wr(mode_prot_pkg::tlb_base_addr + 12'h0a0, 32'h12341406, rs);
    wr(mode_prot_pkg::tlb_base_addr + 12'h0a4, 32'h0def0000, rs);
    tv(0, 6, 32'h11, 5'b01000);
    chk(phys_addr, 32'h0def0123);
    tally_and_finish();
  end
endmodule : mode_and_access_protection_bench
